//--- rtl/mm_burst_agent.sv
`default_nettype none
module mm_burst_agent
  import mm_burst_pkg::*;
#(
  parameter int        ADDR_W      = ADDR_W_DEF,
  parameter int        DATA_W      = DATA_W_DEF,
  parameter int        COUNT_W     = BEAT_COUNT_W_DEF,
  parameter bit        HOLD_FIELDS = 1'b0,          // hold_burst_fields
  parameter unit_sel_t ADDR_UNIT   = UNIT_WORDS,    // address_unit_select
  parameter unit_sel_t COUNT_UNIT  = UNIT_WORDS     // beat_count_unit_select
) (
  mm_burst_if.agent            bus,          // Link from host
  input  wire logic            userStall,    // User back-pressure
  output logic [ADDR_W-1:0]    beatAddr,     // Word address of beat
  output logic [DATA_W-1:0]    beatData,     // Write beat data
  output logic                 beatWrite,    // Write beat strobe
  output logic                 burstDone,    // Write burst accepted
  input  wire logic [DATA_W-1:0] userRdData, // Read beat from store
  output logic                 userRdReq,    // Read beat request
  output logic                 holdViolation // Held fields changed
);
  localparam int SYM_LOG  = $clog2(DATA_W / SYMBOL_W);
  localparam int MAXBURST = 1 << (COUNT_W - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  initial begin
    if (COUNT_W < BEAT_COUNT_W_MIN || COUNT_W > BEAT_COUNT_W_MAX)
      $error("beat count width out of range");
    if ((MAXBURST & (MAXBURST - 1)) != 0)
      $error("maximum burst not a power of two");
    if (ADDR_UNIT == UNIT_SYMBOLS && ADDR_W < COUNT_W + SYM_LOG)
      $error("address too narrow for byte bursts");
    if (ADDR_UNIT == UNIT_WORDS && ADDR_W < COUNT_W)
      $error("address too narrow for word bursts");
    if (DATA_W < SYMBOL_W || DATA_W % SYMBOL_W != 0)
      $error("data width not whole symbols");
    if ((1 << SYM_LOG) != DATA_W / SYMBOL_W)
      $error("symbols per word not a power of two");
    if (RESP_LATENCY_CYC < 1)
      $error("response latency below one cycle");
  end

  // Write burst tracking
  logic [COUNT_W-1:0]  left_q;
  logic                inBurst_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [ADDR_W-1:0]   firstAddr_q;
  logic [COUNT_W-1:0]  firstCount_q;

  // Response pipe and read burst drain
  logic [RESP_LATENCY_CYC-1:0] respPipe_q;
  logic [COUNT_W-1:0]  rdLeft_q;
  logic [ADDR_W-1:0]   rdAddr_q;
  logic                rdPend_q;

  // Decoded view of the current beat
  logic                beatAcc;
  logic                lastBeat;
  logic [COUNT_W-1:0]  startLeft;
  logic [ADDR_W-1:0]   wordAddr;
  logic [COUNT_W-1:0]  beatsIn;

  ////////////////////////////////////////////////////////////////////////////
  // Stall while user blocks or read burst drains
  // High in reset so no host starts before the agent is ready
  // Only one read is in flight: the drain blocks the next command
  assign bus.stallReq = !bus.rst_b || userStall || rdPend_q;
  assign beatAcc      = bus.write && !bus.stallReq;

  // Symbol counts are turned into word beats, a part word rounds up
  // Sum kept one bit wider so a count near the top cannot wrap
  always_comb begin
    beatsIn = bus.beatCount;
    if (COUNT_UNIT == UNIT_SYMBOLS)
      beatsIn = COUNT_W'(({1'b0, bus.beatCount} + (COUNT_W+1)'((1 << SYM_LOG) - 1)) >> SYM_LOG);
    // A zero count from a faulty host still moves one beat
    if (beatsIn == '0)
      beatsIn = COUNT_W'(MIN_BEAT_COUNT);
  end

  // Word address of a first beat; fields only trusted on a first beat
  always_comb begin
    wordAddr  = (ADDR_UNIT == UNIT_SYMBOLS) ? (bus.address >> SYM_LOG) : bus.address;
    startLeft = inBurst_q ? left_q : beatsIn;
  end

  // Last beat taken without stall completes the command
  // Acceptance of the whole write command happens here, not earlier
  assign lastBeat = beatAcc && (startLeft == COUNT_W'(1));

  ////////////////////////////////////////////////////////////////////////////
  // Beat counting: burst start known without the legacy strobe
  // The strobe is never read, so a stalled start cannot mislead it
  // Trade-off: a host that drops a beat desynchronises the next write burst, and later ones too if fields are held
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      left_q       <= '0;
      inBurst_q    <= 1'b0;
      addr_q       <= '0;
      firstAddr_q  <= '0;
      firstCount_q <= '0;
    end else if (beatAcc) begin
      left_q    <= startLeft - COUNT_W'(1);
      inBurst_q <= !lastBeat;
      if (!inBurst_q) begin
        addr_q       <= wordAddr + ADDR_W'(1);
        firstAddr_q  <= bus.address;
        firstCount_q <= bus.beatCount;
      end else begin
        addr_q <= addr_q + ADDR_W'(1);
      end
    end
  end

  // Beat output registers
  // A first beat's address comes straight off the bus
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      beatAddr  <= '0;
      beatData  <= '0;
      beatWrite <= 1'b0;
    end else begin
      beatWrite <= beatAcc;
      if (beatAcc) begin
        beatAddr <= inBurst_q ? addr_q : wordAddr;
        beatData <= bus.writeData;
      end
    end
  end

  // Held-field check: flags a host that drifts mid-burst
  // Stays low when fields are not held, as nothing is compared
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b)
      holdViolation <= 1'b0;
    else if (HOLD_FIELDS && beatAcc && inBurst_q &&
             (bus.address != firstAddr_q || bus.beatCount != firstCount_q))
      holdViolation <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response delayed by at least one cycle after the last beat
  // Pipe length follows the latency constant, one stage per cycle
  // The oldest stage falls off the top of the shift on purpose
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b)
      respPipe_q <= '0;
    else
      respPipe_q <= RESP_LATENCY_CYC'({respPipe_q, lastBeat});
  end
  assign bus.writeRespValid = respPipe_q[RESP_LATENCY_CYC-1];
  assign burstDone          = bus.writeRespValid;

  ////////////////////////////////////////////////////////////////////////////
  // Read burst: one valid per beat, the first two cycles after acceptance
  // Beats stream back to back; the user store must keep pace
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      rdPend_q <= 1'b0;
      rdLeft_q <= '0;
      rdAddr_q <= '0;
    end else if (!rdPend_q) begin
      if (bus.read && !bus.stallReq) begin
        rdPend_q <= 1'b1;
        rdLeft_q <= beatsIn;
        rdAddr_q <= wordAddr;
      end
    end else begin
      rdLeft_q <= rdLeft_q - COUNT_W'(1);
      rdAddr_q <= rdAddr_q + ADDR_W'(1);
      if (rdLeft_q == COUNT_W'(1))
        rdPend_q <= 1'b0;
    end
  end
  assign userRdReq = rdPend_q;

  // Read data registered toward the host
  // Valid trails the request by one cycle, matching the store read
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      bus.readData      <= '0;
      bus.readDataValid <= 1'b0;
    end else begin
      bus.readDataValid <= rdPend_q;
      if (rdPend_q)
        bus.readData <= userRdData;
    end
  end
endmodule
`default_nettype wire

//--- rtl/mm_burst_pkg.sv
`default_nettype none
package mm_burst_pkg;
  // Address and beat-count unit choices
  typedef enum logic [1:0] {
    UNIT_WORDS   = 2'h1,
    UNIT_SYMBOLS = 2'h2
  } unit_sel_t;

  // Documented widths and limits
  localparam int BEAT_COUNT_W_DEF  = 4;
  localparam int BEAT_COUNT_W_MIN  = 1;
  localparam int BEAT_COUNT_W_MAX  = 11;
  localparam int ADDR_W_DEF        = 32;
  localparam int DATA_W_DEF        = 32;
  localparam int SYMBOL_W          = 8;
  localparam int MIN_BEAT_COUNT    = 1;
  // Response latency after the final accepted beat
  localparam int RESP_LATENCY_NS   = 8;
  localparam int CLK_PERIOD_NS     = 8;
  localparam int RESP_LATENCY_CYC  = (RESP_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host burst gap between bursts
  localparam int HOST_IDLE_CYC     = 1;
endpackage
`default_nettype wire

//--- rtl/mm_burst_if.sv
`default_nettype none
interface mm_burst_if #(
  parameter int ADDR_W  = 32,
  parameter int DATA_W  = 32,
  parameter int COUNT_W = 4
) (
  input wire logic ref_clk,                // Shared clock
  input wire logic rst_b                   // Shared reset, active low
);
  logic [ADDR_W-1:0]   address;            // Burst start address
  logic [COUNT_W-1:0]  beatCount;          // Beats in burst
  logic                write;              // Write beat valid
  logic                read;               // Read command valid
  logic [DATA_W-1:0]   writeData;          // Write beat data
  logic                stallReq;           // Agent stall request
  logic                burstStart;         // Legacy burst-start strobe
  logic [DATA_W-1:0]   readData;           // Read beat data
  logic                readDataValid;      // Read beat strobe
  logic                writeRespValid;     // Write response strobe

  modport host (
    input  ref_clk, rst_b, stallReq, readData, readDataValid, writeRespValid,
    output address, beatCount, write, read, writeData, burstStart
  );
  modport agent (
    input  ref_clk, rst_b, address, beatCount, write, read, writeData, burstStart,
    output stallReq, readData, readDataValid, writeRespValid
  );
endinterface
`default_nettype wire

//--- rtl/mm_burst_host.sv
`default_nettype none
module mm_burst_host
  import mm_burst_pkg::*;
#(
  parameter int        ADDR_W          = ADDR_W_DEF,
  parameter int        DATA_W          = DATA_W_DEF,
  parameter int        COUNT_W         = BEAT_COUNT_W_DEF,
  parameter bit        FULL_LEN_ONLY   = 1'b0,   // full_length_bursts_only
  parameter bit        ALIGNED_STARTS  = 1'b0,   // aligned_burst_starts
  parameter bit        HOLD_FIELDS     = 1'b0,   // hold_burst_fields
  parameter unit_sel_t ADDR_UNIT       = UNIT_SYMBOLS,
  parameter unit_sel_t COUNT_UNIT      = UNIT_WORDS
) (
  mm_burst_if.host             bus,            // Link to agent
  input  wire logic            cmdValid,       // User burst request
  output logic                 cmdReady,       // Request taken
  input  wire logic            cmdWrite,       // 1 write, 0 read
  input  wire logic [ADDR_W-1:0]  cmdAddr,     // Burst start address
  input  wire logic [COUNT_W-1:0] cmdCount,    // Requested beats
  input  wire logic [DATA_W-1:0]  wrData,      // Next write beat
  output logic                 wrTake,         // Write beat consumed
  output logic [DATA_W-1:0]    rdData,         // Read beat data
  output logic                 rdValid,        // Read beat strobe
  output logic                 wrDone          // Write response seen
);
  localparam int SYM_LOG  = $clog2(DATA_W / SYMBOL_W);
  localparam int MAXBURST = 1 << (COUNT_W - 1);

  // Width checks on the configuration
  initial begin
    if (COUNT_W < BEAT_COUNT_W_MIN || COUNT_W > BEAT_COUNT_W_MAX)
      $error("beat count width out of range");
    if (ADDR_UNIT == UNIT_SYMBOLS && ADDR_W < COUNT_W + SYM_LOG)
      $error("address too narrow for burst");
    if (ADDR_UNIT == UNIT_WORDS && ADDR_W < COUNT_W)
      $error("address too narrow for burst");
  end

  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_WRITE = 3'b010,
    H_READ  = 3'b100
  } host_state_t;

  host_state_t          state_q;
  logic [COUNT_W-1:0]   left_q;
  logic [COUNT_W-1:0]   count_q;
  logic [ADDR_W-1:0]    addr_q;
  logic                 first_q;
  logic                 fieldsOn_q;
  logic [COUNT_W-1:0]   reqCount;
  logic [ADDR_W-1:0]    reqAddr;
  logic                 beatGo;

  // Full length forces the largest count; zero counts rise to one
  always_comb begin
    if (FULL_LEN_ONLY)
      reqCount = COUNT_W'(MAXBURST);
    else if (cmdCount < COUNT_W'(MIN_BEAT_COUNT))
      reqCount = COUNT_W'(MIN_BEAT_COUNT);
    else
      reqCount = cmdCount;
    reqAddr = cmdAddr;
    if (ALIGNED_STARTS)
      reqAddr = cmdAddr & ~ADDR_W'((MAXBURST << ((ADDR_UNIT == UNIT_SYMBOLS) ? SYM_LOG : 0)) - 1);
  end

  assign cmdReady = (state_q == H_IDLE);
  assign beatGo   = (state_q == H_WRITE) && !bus.stallReq;
  assign wrTake   = beatGo;

  // Command sequencing, controls held while stalled
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      state_q <= H_IDLE;
      left_q  <= '0;
      count_q <= '0;
      addr_q  <= '0;
      first_q <= 1'b0;
      fieldsOn_q <= 1'b0;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (cmdValid) begin
            state_q <= cmdWrite ? H_WRITE : H_READ;
            left_q  <= reqCount;
            count_q <= reqCount;
            addr_q  <= reqAddr;
            first_q <= 1'b1;
            fieldsOn_q <= 1'b1;
          end
        end
        H_WRITE: begin
          first_q <= 1'b0;
          if (!bus.stallReq) begin
            left_q <= left_q - COUNT_W'(1);
            fieldsOn_q <= 1'b0;
            if (left_q == COUNT_W'(1))
              state_q <= H_IDLE;
          end
        end
        H_READ: begin
          first_q <= 1'b0;
          if (!bus.stallReq) begin
            state_q    <= H_IDLE;
            fieldsOn_q <= 1'b0;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // Fields stand until the first beat is taken, so a stalled start keeps them
  always_comb begin
    bus.write      = (state_q == H_WRITE);
    bus.read       = (state_q == H_READ);
    bus.writeData  = wrData;
    bus.burstStart = first_q;
    bus.address    = (fieldsOn_q || HOLD_FIELDS) ? addr_q : '0;
    bus.beatCount  = (fieldsOn_q || HOLD_FIELDS) ? count_q : '0;
  end

  // Read data arrives on its own strobe
  always_ff @(posedge bus.ref_clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      rdData  <= '0;
      rdValid <= 1'b0;
      wrDone  <= 1'b0;
    end else begin
      rdValid <= bus.readDataValid;
      if (bus.readDataValid)
        rdData <= bus.readData;
      wrDone  <= bus.writeRespValid;
    end
  end
endmodule
`default_nettype wire

//--- test/mm_burst_chk.sv
`default_nettype none
module mm_burst_chk #(
  parameter int ADDR_W  = 32,
  parameter int DATA_W  = 32,
  parameter int COUNT_W = 4
) (
  input wire logic               ref_clk,        // Shared clock
  input wire logic               rst_b,          // Reset, active low
  input wire logic [ADDR_W-1:0]  address,        // Burst address
  input wire logic [COUNT_W-1:0] beatCount,      // Beats in burst
  input wire logic               write,          // Write beat valid
  input wire logic               read,           // Read command valid
  input wire logic [DATA_W-1:0]  writeData,      // Write beat data
  input wire logic               stallReq,       // Agent stall
  input wire logic               burstStart,     // Legacy start strobe
  input wire logic               readDataValid,  // Read beat strobe
  input wire logic               writeRespValid  // Write response
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAXB = 1 << (COUNT_W - 1);
  logic [COUNT_W-1:0] remQ;
  logic               beatAcc;
  logic               firstBeat;
  logic               lastAcc;

  // Own beat tracking, so the checker never trusts the agent's count
  assign beatAcc   = write && !stallReq;
  assign firstBeat = (remQ == '0);
  assign lastAcc   = beatAcc && (firstBeat ? beatCount <= 1 : remQ == 1);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) remQ <= '0;
    else if (beatAcc) remQ <= firstBeat ? beatCount - 1'b1 : remQ - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence writeBeatS;
    write && !stallReq;
  endsequence
  sequence lastBeatS;
    writeBeatS ##0 lastAcc;
  endsequence

  chk_resp_one_cycle: assert property (lastBeatS |=> writeRespValid)
    else $error("write response missing after last beat");
  chk_resp_not_early: assert property (writeRespValid |-> $past(lastAcc))
    else $error("write response without accepted last beat");
  chk_start_single: assert property (burstStart |=> !burstStart)
    else $error("burst start wider than one cycle");
  chk_start_first: assert property (burstStart |-> firstBeat && (write || read))
    else $error("burst start off the first beat");
  chk_count_range: assert property (burstStart |-> beatCount <= MAXB)
    else $error("beat count above maximum");
  chk_count_nonzero: assert property ((write || read) && firstBeat |-> beatCount != 0)
    else $error("beat count below one");
  chk_stall_hold: assert property ((write || read) && stallReq |=>
    $stable({write, read, address, beatCount, writeData}))
    else $error("host controls moved under stall");
  chk_fields_first: assert property (write && !firstBeat |-> beatCount == '0)
    else $error("beat count driven after first beat");
  chk_read_data_lat: assert property (read && !stallReq |-> ##2 readDataValid)
    else $error("read data not two cycles after accept");
endmodule
`default_nettype wire

//--- test/tb_top.sv
`default_nettype none
module tb_top
  import mm_burst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr; logic [31:0] addr; logic [3:0] cnt; logic stall;
    logic [31:0] expAddr; logic [3:0] expCnt;
  } row_t;
  logic ref_clk, rst_b, cmdValid, cmdReady, cmdWrite, wrTake, rdValid, wrDone;
  logic userStall, stallEn, beatWrite, burstDone, userRdReq, holdViolation;
  logic [31:0] cmdAddr, wrData, rdData, beatAddr, beatData, userRdData;
  logic [3:0]  cmdCount;
  int          errTotal, checked;
  int          cycles = 0;
  // Min, max, stalled, unaligned start, zero count, reads
  row_t rows[7] = '{
    '{1'b1, 32'h0000_0010, 4'h1, 1'b0, 32'h0000_0010, 4'h1},
    '{1'b1, 32'h0000_0020, 4'h8, 1'b0, 32'h0000_0020, 4'h8},
    '{1'b1, 32'h0000_0040, 4'h5, 1'b1, 32'h0000_0040, 4'h5},
    '{1'b1, 32'h0000_0053, 4'h2, 1'b0, 32'h0000_0050, 4'h2},
    '{1'b1, 32'h0000_0060, 4'h0, 1'b0, 32'h0000_0060, 4'h1},
    '{1'b0, 32'h0000_0080, 4'h8, 1'b0, 32'h0000_0080, 4'h8},
    '{1'b0, 32'h0000_0090, 4'h3, 1'b1, 32'h0000_0090, 4'h3}};

  mm_burst_if link (.ref_clk(ref_clk), .rst_b(rst_b));
  mm_burst_host #(.ALIGNED_STARTS(1'b1), .ADDR_UNIT(UNIT_WORDS)) mm_burst_host_i (
    .bus(link.host), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
    .cmdAddr(cmdAddr), .cmdCount(cmdCount), .wrData(wrData), .wrTake(wrTake),
    .rdData(rdData), .rdValid(rdValid), .wrDone(wrDone));
  mm_burst_agent mm_burst_agent_i (
    .bus(link.agent), .userStall(userStall), .beatAddr(beatAddr), .beatData(beatData),
    .beatWrite(beatWrite), .burstDone(burstDone), .userRdData(userRdData),
    .userRdReq(userRdReq), .holdViolation(holdViolation));
  mm_burst_chk #(.ADDR_W(32), .DATA_W(32), .COUNT_W(4)) mm_burst_chk_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .address(link.address), .beatCount(link.beatCount),
    .write(link.write), .read(link.read), .writeData(link.writeData),
    .stallReq(link.stallReq), .burstStart(link.burstStart),
    .readDataValid(link.readDataValid), .writeRespValid(link.writeRespValid));

  ////////////////////////////////////////////////////////////////////////
  // Clock, stall toggling and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    #1;
    userStall <= stallEn & ~userStall;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errTotal++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One burst; tail cycles catch late strobes after completion
  task automatic runRow(input row_t r, input logic [31:0] rdPat);
    int sent, seen, dones, bursts, n, tail, reqs;
    logic take;
    sent = 0; seen = 0; dones = 0; bursts = 0; n = 0; tail = 0; reqs = 0;
    cmdValid = 1'b1; cmdWrite = r.wr; cmdAddr = r.addr; cmdCount = r.cnt;
    wrData = 32'hC0DE_0000; userRdData = rdPat; stallEn = r.stall;
    @(negedge ref_clk);
    while (!cmdReady) @(negedge ref_clk);
    @(posedge ref_clk);
    #1 cmdValid = 1'b0;
    while (n < 40 && tail < 3) begin
      @(negedge ref_clk);
      take = wrTake;
      if (beatWrite === 1'b1) begin
        chk("beatAddr", r.expAddr + 32'(seen), beatAddr);
        chk("beatData", 32'hC0DE_0000 + 32'(seen), beatData);
        seen++;
      end
      if (rdValid === 1'b1) begin
        chk("rdData", rdPat, rdData);
        seen++;
      end
      if (wrDone === 1'b1) dones++;
      if (burstDone === 1'b1) bursts++;
      if (userRdReq === 1'b1) reqs++;
      if (r.wr ? dones > 0 : seen == int'(r.expCnt)) tail++;
      @(posedge ref_clk);
      #1;
      if (take === 1'b1) begin
        sent++;
        wrData = 32'hC0DE_0000 + 32'(sent);
      end
      n++;
    end
    stallEn = 1'b0;
    chk("beats", 32'(r.expCnt), 32'(seen));
    chk("wrTakes", r.wr ? 32'(r.expCnt) : 32'h0000_0000, 32'(sent));
    chk("wrDone", 32'(r.wr), 32'(dones));
    chk("burstDone", 32'(r.wr), 32'(bursts));
    chk("rdReqs", r.wr ? 32'h0000_0000 : 32'(r.expCnt), 32'(reqs));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: table, then reset while idle and the max row again
  initial begin
    rst_b = 1'b0; cmdValid = 1'b0; cmdWrite = 1'b0; cmdAddr = '0; cmdCount = '0;
    wrData = '0; userRdData = '0; stallEn = 1'b0;
    errTotal = 0; checked = 0;
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 7; i++) begin
      runRow(rows[i], 32'h5EED_0000 + 32'(i));
    end
    chk("holdViolation", 32'h0000_0000, 32'(holdViolation));
    @(posedge ref_clk);
    #1 rst_b = 1'b0;
    @(negedge ref_clk);
    chk("stallInReset", 32'h0000_0001, 32'(link.stallReq));
    chk("outsInReset", 32'h0000_0000,
        32'({beatWrite, burstDone, rdValid, wrDone, userRdReq, holdViolation}));
    @(posedge ref_clk);
    #1 rst_b = 1'b1;
    runRow(rows[1], 32'h5EED_0010);
    print_verdict();
  end
endmodule
`default_nettype wire
